// ==== rtl/trpd_pkg.sv ====
// package of constants and types for the test/reset pin and defaults block
package trpd_pkg;
	// register offsets
	localparam logic [7:0] CAL_CTRL_ADDR   = 8'h08;
	localparam logic [7:0] ANA_CAL_ADDR    = 8'h12;
	// field positions
	localparam int FT_BIT                  = 6;
	// power-on values
	localparam logic [7:0] CAL_CTRL_RESET  = 8'h00;
	localparam logic [7:0] ANA_CAL_RESET   = 8'h00;
	// timing
	localparam int CORE_CLK_HZ             = 250_000_000;
	localparam int TEST_TONE_HZ            = 512;
	localparam int TRIM_WAIT_MS            = 8;
	localparam int TRIM_WAIT_CYC           = CORE_CLK_HZ / 1000 * TRIM_WAIT_MS;
	// power-up kind
	localparam logic PWR_INITIAL           = 1'b0;

	// bits that carry power-on defaults
	typedef struct packed {
		logic       halt_flag;
		logic       osc_fail_flag;
		logic       timer_run_enable;
		logic       timer_irq_pulse_mode;
		logic       timer_irq_enable;
		logic       timer_clock_sel_hi;
		logic       timer_clock_sel_lo;
		logic       rate_sel_lsb;
		logic [2:0] rate_sel_upper;
		logic       factory_trim_sel;
		logic       alarm_two_irq_enable;
		logic       alarm_two_enable;
		logic [4:0] alarm_one_repeat_bits;
		logic [4:0] alarm_two_repeat_bits;
	} trpd_ctrl_type;

	localparam trpd_ctrl_type CTRL_INITIAL = '{
		halt_flag: 1'b1, osc_fail_flag: 1'b1, timer_run_enable: 1'b0,
		timer_irq_pulse_mode: 1'b0, timer_irq_enable: 1'b0,
		timer_clock_sel_hi: 1'b1, timer_clock_sel_lo: 1'b1,
		rate_sel_lsb: 1'b1, rate_sel_upper: 3'h0, factory_trim_sel: 1'b0,
		alarm_two_irq_enable: 1'b0, alarm_two_enable: 1'b0,
		alarm_one_repeat_bits: 5'h00, alarm_two_repeat_bits: 5'h00};

	// register access request, write or read
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} trpd_req_type;

	typedef enum logic [1:0] {
		TRIM_IDLE = 2'b00,
		TRIM_COPY = 2'b01,
		TRIM_DONE = 2'b10
	} trpd_trim_state_type;
endpackage : trpd_pkg

// ==== rtl/trpd_top.sv ====
// shared test/reset pin, power-on defaults and factory trim load
`timescale 1ns/100ps
`default_nettype none

module trpd_top
	import trpd_pkg::*;
#(
	parameter int TRIM_WAIT = TRIM_WAIT_CYC
) (
	// clock and reset
	input  wire  logic          I_CORE_CLK,
	input  wire  logic          I_RSTN,
	// power status
	input  wire  logic          i_supply_good,
	input  wire  logic          i_backed_powerup,
	input  wire  logic          i_osc_32k,
	// register port from serial bus decoder
	input  wire  trpd_req_type  i_req,
	input  wire  logic [7:0]    i_ctrl_wdata_mask,
	input  wire  trpd_ctrl_type i_ctrl_wr,
	input  wire  logic          i_ctrl_we,
	input  wire  logic [7:0]    i_otp_trim,
	output var   logic [7:0]    o_rdata,
	output var   trpd_ctrl_type o_ctrl,
	output var   logic          o_trim_ready,
	// shared test/reset pin, open drain
	output var   logic          o_shared_test_reset_pin,
	output var   logic          o_shared_test_reset_pin_oe
);
	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	logic [2:0] sg_sync;
	logic [2:0] osc_sync;
	logic       supply_ok;
	logic       osc_lvl;
	logic       osc_q;

	// three stages; a change counts once stages two and three agree
	always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			sg_sync  <= 3'h0;
			osc_sync <= 3'h0;
		end else begin
			sg_sync  <= {sg_sync[1:0], i_supply_good};
			osc_sync <= {osc_sync[1:0], i_osc_32k};
		end
	end

	// filtered levels; supply starts out failed
	always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			supply_ok <= 1'b0;
			osc_lvl   <= 1'b0;
			osc_q     <= 1'b0;
		end else begin
			if (sg_sync[1] == sg_sync[2])
				supply_ok <= sg_sync[2];
			if (osc_sync[1] == osc_sync[2])
				osc_lvl <= osc_sync[2];
			osc_q <= osc_lvl;
		end
	end

	// ----------------------------------------------------------------
	// 512 Hz tone: 32768 / 64, toggle every 32 oscillator rises
	// ----------------------------------------------------------------
	logic [4:0] tone_div;
	logic       tone;
	wire        osc_rise = osc_lvl & ~osc_q;

	always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			tone_div <= 5'h00;
			tone     <= 1'b0;
		end else if (osc_rise) begin
			tone_div <= tone_div + 5'h01;
			if (tone_div == 5'h1F)
				tone <= ~tone;
		end
	end

	// ----------------------------------------------------------------
	// control registers and power-up defaults
	// ----------------------------------------------------------------
	logic [7:0]    cal_ctrl;
	logic [7:0]    ana_cal;
	trpd_ctrl_type ctrl;
	logic          pwr_seen;
	logic          sup_q;

	wire wr_cal   = i_req.wr && (i_req.addr == CAL_CTRL_ADDR);
	wire wr_ana   = i_req.wr && (i_req.addr == ANA_CAL_ADDR);
	wire sup_rise = supply_ok & ~sup_q;

	trpd_trim_state_type trim_st;
	trpd_trim_state_type next_trim_st;
	logic [31:0]         trim_cnt;

	// calibration control: test bit cleared by supply fail and power-up
	always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			cal_ctrl <= CAL_CTRL_RESET;
			sup_q    <= 1'b0;
		end else begin
			sup_q <= supply_ok;
			if (!supply_ok)
				cal_ctrl[FT_BIT] <= 1'b0;
			else if (wr_cal)
				cal_ctrl <= i_req.wdata;
		end
	end

	// default bits; non-listed bits are untouched here
	always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			ctrl     <= CTRL_INITIAL;
			pwr_seen <= 1'b0;
		end else if (sup_rise) begin
			pwr_seen <= 1'b1;
			if (!pwr_seen && i_backed_powerup == PWR_INITIAL)
				ctrl <= CTRL_INITIAL;
			else begin
				ctrl.halt_flag        <= 1'b1;
				ctrl.timer_run_enable <= 1'b0;
			end
		end else if (i_ctrl_we && supply_ok)
			ctrl <= i_ctrl_wr;
	end

	// analog calibration: writable only with trim select low
	always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
		if (!I_RSTN)
			ana_cal <= ANA_CAL_RESET;
		else if (trim_st == TRIM_COPY && trim_cnt == 32'(TRIM_WAIT - 1))
			ana_cal <= i_otp_trim;
		else if (wr_ana && !ctrl.factory_trim_sel)
			ana_cal <= i_req.wdata;
	end

	// ----------------------------------------------------------------
	// trim transfer sequencer
	// ----------------------------------------------------------------
	always_comb begin
		next_trim_st = trim_st;
		case (trim_st)
			TRIM_IDLE: if (ctrl.factory_trim_sel) next_trim_st = TRIM_COPY;
			TRIM_COPY: begin
				if (!ctrl.factory_trim_sel)
					next_trim_st = TRIM_IDLE;
				else if (trim_cnt == 32'(TRIM_WAIT - 1))
					next_trim_st = TRIM_DONE;
			end
			TRIM_DONE: if (!ctrl.factory_trim_sel) next_trim_st = TRIM_IDLE;
			default:   next_trim_st = TRIM_IDLE;
		endcase
	end

	// the wait models the transfer the host must allow
	always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			trim_st  <= TRIM_IDLE;
			trim_cnt <= 32'h0;
		end else begin
			trim_st  <= next_trim_st;
			trim_cnt <= (trim_st == TRIM_COPY) ? trim_cnt + 32'h1 : 32'h0;
		end
	end

	// ----------------------------------------------------------------
	// outputs, all registered
	// ----------------------------------------------------------------
	wire [7:0] rd_mux = (i_req.addr == CAL_CTRL_ADDR) ? cal_ctrl :
	                    (i_req.addr == ANA_CAL_ADDR)  ? ana_cal  : 8'h00;
	wire pin_level    = !supply_ok ? 1'b0 :
	                    cal_ctrl[FT_BIT] ? tone :
	                    1'b1;

	always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			o_rdata                    <= 8'h00;
			o_ctrl                     <= CTRL_INITIAL;
			o_trim_ready               <= 1'b0;
			o_shared_test_reset_pin    <= 1'b0;
			o_shared_test_reset_pin_oe <= 1'b1;
		end else begin
			o_rdata                    <= i_req.rd ? rd_mux : 8'h00;
			o_ctrl                     <= ctrl;
			o_trim_ready               <= (trim_st == TRIM_DONE);
			o_shared_test_reset_pin    <= pin_level;
			o_shared_test_reset_pin_oe <= ~pin_level; // open drain
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	AST_FAIL_LOW: assert property (@(posedge I_CORE_CLK) disable iff (!I_RSTN)
		!supply_ok |=> !o_shared_test_reset_pin && !cal_ctrl[FT_BIT])
		else $error("pin not low on supply fail");
	AST_IDLE_HIGH: assert property (@(posedge I_CORE_CLK) disable iff (!I_RSTN)
		supply_ok && !cal_ctrl[FT_BIT] |=> o_shared_test_reset_pin)
		else $error("pin not high when idle");
	AST_TONE: assert property (@(posedge I_CORE_CLK) disable iff (!I_RSTN)
		supply_ok && cal_ctrl[FT_BIT] |=> o_shared_test_reset_pin == $past(tone))
		else $error("pin does not follow tone");
	AST_HALT: assert property (@(posedge I_CORE_CLK) disable iff (!I_RSTN)
		sup_rise |=> ctrl.halt_flag && !ctrl.timer_run_enable)
		else $error("halt not forced on power-up");
	AST_RO: assert property (@(posedge I_CORE_CLK) disable iff (!I_RSTN)
		trim_st == TRIM_DONE && ctrl.factory_trim_sel |=> $stable(ana_cal))
		else $error("trim register changed");
	AST_RW: assert property (@(posedge I_CORE_CLK) disable iff (!I_RSTN)
		wr_ana && !ctrl.factory_trim_sel && trim_st != TRIM_COPY
		|=> ana_cal == $past(i_req.wdata))
		else $error("calibration write lost");
	AST_READY: assert property (@(posedge I_CORE_CLK) disable iff (!I_RSTN)
		$rose(o_trim_ready) |-> ana_cal == $past(i_otp_trim, 2))
		else $error("ready before copy");
	AST_COPY_OLD: assert property (@(posedge I_CORE_CLK) disable iff (!I_RSTN)
		trim_st == TRIM_COPY && trim_cnt != 32'(TRIM_WAIT - 1) |=> $stable(ana_cal))
		else $error("value changed during copy");

	// trim select seen while idle, then the copy must start
	sequence seq_trim_request;
		trim_st == TRIM_IDLE && ctrl.factory_trim_sel;
	endsequence
	sequence seq_trim_running;
		trim_st == TRIM_COPY && trim_cnt == 32'h0;
	endsequence
	AST_COPY_START: assert property (@(posedge I_CORE_CLK) disable iff (!I_RSTN)
		seq_trim_request |=> seq_trim_running)
		else $error("trim copy did not start");
endmodule // trpd_top

`default_nettype wire

// ==== testbench/testbench.sv ====
// self-checking bench of the test/reset pin block
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import trpd_pkg::*;
	logic clk = 0, rstn = 0, sg = 0, bk = 0, osc = 0, we = 0;
	trpd_req_type req = '0;
	trpd_ctrl_type cw = CTRL_INITIAL;
	trpd_ctrl_type ctl;
	logic [7:0] rdat;
	logic rdy, oe, lvl, pin;
	real per;
	int n_errors = 0;
	int samples_checked = 0;
	// fast oscillator keeps the tone within a short run
	always #2 clk = ~clk;
	always #20 osc = ~osc;
	trpd_top #(.TRIM_WAIT(16)) uut (.I_CORE_CLK(clk), .I_RSTN(rstn),
		.i_supply_good(sg), .i_backed_powerup(bk), .i_osc_32k(osc),
		.i_req(req), .i_ctrl_wdata_mask(8'h00), .i_ctrl_wr(cw),
		.i_ctrl_we(we), .i_otp_trim(8'h3C), .o_rdata(rdat),
		.o_ctrl(ctl), .o_trim_ready(rdy), .o_shared_test_reset_pin(pin),
		.o_shared_test_reset_pin_oe(oe));
	trpd_host host (.i_oe(oe), .o_lvl(lvl), .o_per(per));
	// --------
	// shared tasks
	// --------
	task automatic chk(input logic [23:0] g, e, input string m);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %0t %s", $time, m);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	// one register access, read data sampled after the taking edge
	task automatic acc(input logic w, input logic [7:0] a, d);
		@(posedge clk);
		req <= '{wr: w, rd: !w, addr: a, wdata: d};
		@(posedge clk);
		req <= '0;
		#1;
	endtask
	task automatic conclude;
		$display("checked %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// --------
	// scenarios
	// --------
	task automatic t_boot;
		chk(24'(ctl), 24'(CTRL_INITIAL), "defaults");
		chk(24'(lvl), 24'h1, "idle pin");
		chk(24'(pin), 24'h1, "idle pin level");
		acc(0, CAL_CTRL_ADDR, 8'h00);
		chk(24'(rdat[FT_BIT]), 24'h0, "test bit");
		$display("boot done");
	endtask
	task automatic t_tone;
		acc(1, CAL_CTRL_ADDR, 8'h40);
		acc(0, CAL_CTRL_ADDR, 8'h00);
		chk(24'(rdat), 24'h40, "ctrl readback");
		cyc(2000);
		// 64 oscillator periods of 40 ns
		chk(24'(per > 2555.0 && per < 2565.0), 24'h1, "tone");
		$display("tone done");
	endtask
	task automatic t_fail;
		@(posedge clk);
		sg <= 0;
		cyc(8);
		#1;
		chk(24'(lvl), 24'h0, "reset low");
		chk(24'(pin), 24'h0, "reset level");
		@(posedge clk);
		sg <= 1;
		cyc(12);
		acc(0, CAL_CTRL_ADDR, 8'h00);
		chk(24'(rdat[FT_BIT]), 24'h0, "test bit cleared");
		chk(24'(lvl), 24'h1, "pin released");
		$display("fail done");
	endtask
	task automatic t_trim;
		acc(1, ANA_CAL_ADDR, 8'hA5);
		acc(0, ANA_CAL_ADDR, 8'h00);
		chk(24'(rdat), 24'hA5, "plain write");
		@(posedge clk);
		cw.factory_trim_sel <= 1'b1;
		we <= 1'b1;
		@(posedge clk);
		we <= 1'b0;
		acc(0, ANA_CAL_ADDR, 8'h00);
		chk(24'(rdat), 24'hA5, "old value");
		acc(1, ANA_CAL_ADDR, 8'h5A);
		// host holds off until the copy is reported done
		for (int i = 0; i < 100 && rdy !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		chk(24'(rdy), 24'h1, "trim ready");
		if (rdy !== 1'b1)
			conclude();
		acc(0, ANA_CAL_ADDR, 8'h00);
		chk(24'(rdat), 24'h3C, "trim copied");
		acc(1, ANA_CAL_ADDR, 8'h5A);
		acc(0, ANA_CAL_ADDR, 8'h00);
		chk(24'(rdat), 24'h3C, "read only");
		$display("trim done");
	endtask
	task automatic t_backed;
		trpd_ctrl_type e;
		@(posedge clk);
		cw.halt_flag <= 1'b0;
		cw.osc_fail_flag <= 1'b0;
		cw.timer_run_enable <= 1'b1;
		cw.rate_sel_upper <= 3'h5;
		we <= 1'b1;
		@(posedge clk);
		we <= 1'b0;
		sg <= 1'b0;
		bk <= 1'b1;
		e = cw;
		e.halt_flag = 1'b1;
		e.timer_run_enable = 1'b0;
		cyc(10);
		sg <= 1'b1;
		cyc(12);
		#1;
		chk(24'(ctl), 24'(e), "backed defaults");
		$display("backed done");
	endtask
	// reset, supply up, then the scenarios in turn
	initial begin
		cyc(6);
		rstn <= 1'b1;
		sg <= 1'b1;
		cyc(12);
		#1;
		t_boot();
		t_tone();
		t_fail();
		t_trim();
		t_backed();
		conclude();
	end
endmodule // testbench
`default_nettype wire

// ==== testbench/trpd_host.sv ====
// host side of the shared pin: pull-up and tone period
`timescale 1ns/100ps
`default_nettype none
module trpd_host (
	// pin enable from the device
	input  wire logic i_oe,
	// resolved wire level and last period seen
	output var  logic o_lvl,
	output var  real  o_per
);
	real last = 0.0;
	// --------
	// open drain wire, pull-up wins when released
	// --------
	assign o_lvl = ~i_oe;
	// period between rises, to judge the test tone
	always @(posedge o_lvl) begin
		o_per = $realtime - last;
		last = $realtime;
	end
endmodule // trpd_host
`default_nettype wire
